// ### hw/nbp_regs.svh
// Timing counts and address layout for the NAND pin sequencer.
// Assumes a 125 MHz system clock; counts are in clock cycles.
`ifndef NBP_REGS_SVH
`define NBP_REGS_SVH
// Strobe low and high phase, in ns and derived cycles
`define NBP_CLK_PERIOD_NS 8
`define NBP_WE_LOW_NS 24
`define NBP_WE_HIGH_NS 16
`define NBP_RD_ACCESS_NS 24
`define NBP_WE_LOW_CYC ((`NBP_WE_LOW_NS + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)
`define NBP_WE_HIGH_CYC ((`NBP_WE_HIGH_NS + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)
`define NBP_RD_ACCESS_CYC ((`NBP_RD_ACCESS_NS + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)
// Read path lag: pin register, three input flops, agreement stage
`define NBP_RD_SYNC_CYC 5
`define NBP_RD_LOW_CYC (`NBP_RD_ACCESS_CYC + `NBP_RD_SYNC_CYC)
// Cycles before the filtered ready level is trusted after a command
`define NBP_BUSY_GUARD_CYC 8
// Address geometry
`define NBP_ADDR_CYCLES 5
`define NBP_COL_BITS 12
`define NBP_ROW_BITS 17
`define NBP_PLANE_BIT 6
`define NBP_PAGE_MAIN_BYTES 2048
`define NBP_PAGE_SPARE_BYTES 64
`define NBP_PAGES_PER_BLOCK 64
`define NBP_BLOCKS 2048
`endif

// ### hw/nbp_pkg.sv
// Types shared by the NAND pin sequencer files.
// Assumes nbp_regs.svh supplies the numeric constants.
package nbp_pkg;
  // Kind of one bus cycle
  typedef enum logic [1:0] {
    NBP_CYC_CMD = 2'h0,
    NBP_CYC_ADDR = 2'h1,
    NBP_CYC_WDATA = 2'h2,
    NBP_CYC_RDATA = 2'h3
  } nbp_cyc_t;
  // Strobe engine states, one bit changes from IDLE to LOW and from LOW to HIGH
  typedef enum logic [1:0] {
    NBP_ST_IDLE = 2'b00,
    NBP_ST_LOW = 2'b01,
    NBP_ST_HIGH = 2'b11
  } nbp_st_t;
endpackage : nbp_pkg

// ### hw/nbp_cyc_if.sv
// Request and answer path between the sequencer and its strobe engine.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface nbp_cyc_if;
  import nbp_pkg::*;
  logic req;
  nbp_cyc_t kind;
  logic [7:0] wbyte;
  logic done;
  logic [7:0] rbyte;
  modport seq (output req, output kind, output wbyte,
               input done, input rbyte);
  modport eng (input req, input kind, input wbyte,
               output done, output rbyte);
endinterface : nbp_cyc_if

// ### hw/nbp_strobe.sv
// Strobe engine: turns one cycle request into a pin-level bus cycle.
// Assumes io_in is already synchronised by the caller.
`timescale 1ns/1ps
`include "nbp_regs.svh"
module nbp_strobe
  import nbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  nbp_cyc_if.eng cyc,
  input wire logic [7:0] io_in_i,
  output logic cmd_latch_o,
  output logic addr_latch_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic [7:0] io_out_o,
  output logic io_oe_o
);
  nbp_st_t st;
  logic [3:0] cnt;
  nbp_cyc_t kind;
  wire is_rd = (kind == NBP_CYC_RDATA);
  wire cnt_zero = (cnt == 4'h0);
  // Read low phase also covers the pin register and input filter lag
  wire [3:0] low_cyc = (cyc.kind == NBP_CYC_RDATA) ?
                       4'(`NBP_RD_LOW_CYC) : 4'(`NBP_WE_LOW_CYC);
  // Cycle sequencing; the engine finishes one cycle before taking another
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= NBP_ST_IDLE;
      cnt <= 4'h0;
      kind <= NBP_CYC_CMD;
      cmd_latch_o <= 1'b0;
      addr_latch_o <= 1'b0;
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      io_out_o <= 8'h00;
      io_oe_o <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rbyte <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      case (st)
        NBP_ST_IDLE: begin
          if (cyc.req) begin
            kind <= cyc.kind;
            cmd_latch_o <= (cyc.kind == NBP_CYC_CMD);
            addr_latch_o <= (cyc.kind == NBP_CYC_ADDR);
            io_out_o <= cyc.wbyte;
            io_oe_o <= (cyc.kind != NBP_CYC_RDATA);
            st <= NBP_ST_LOW;
            cnt <= low_cyc;
          end
        end
        NBP_ST_LOW: begin
          // read only with latches low, WE high
          write_strobe_n_o <= is_rd;
          read_strobe_n_o <= !is_rd;
          if (cnt_zero) begin
            write_strobe_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            if (is_rd)
              cyc.rbyte <= io_in_i;
            cnt <= 4'(`NBP_WE_HIGH_CYC);
            st <= NBP_ST_HIGH;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        NBP_ST_HIGH: begin
          if (cnt_zero) begin
            cmd_latch_o <= 1'b0;
            addr_latch_o <= 1'b0;
            io_oe_o <= 1'b0;
            cyc.done <= 1'b1;
            st <= NBP_ST_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: st <= NBP_ST_IDLE;
      endcase
    end
  end
endmodule : nbp_strobe

// ### hw/nbp_host.sv
// Host-side NAND pin sequencer: takes one user operation (command,
// optional five address bytes, optional second command, data bytes)
// and plays it onto the device pins. Assumes a single device whose
// ready/busy pin has an external pull-up.
`timescale 1ns/1ps
`include "nbp_regs.svh"
module nbp_host
  import nbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic op_start_i,
  input wire logic [7:0] op_cmd1_i,
  input wire logic op_addr_en_i,
  input wire logic [11:0] op_col_i,
  input wire logic [16:0] op_row_i,
  input wire logic op_cmd2_en_i,
  input wire logic [7:0] op_cmd2_i,
  input wire logic op_wait_busy_i,
  input wire logic op_is_write_i,
  input wire logic [11:0] op_len_i,
  input wire logic wdata_valid_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_protect_en_i,
  output logic op_busy_o,
  output logic op_done_o,
  output logic wdata_ready_o,
  output logic rdata_valid_o,
  output logic [7:0] rdata_o,
  output logic chip_enable_n_o,
  output logic cmd_latch_o,
  output logic addr_latch_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic write_protect_n_o,
  input wire logic ready_busy_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o
);
  typedef enum logic [2:0] {
    NBP_PH_IDLE = 3'b000,
    NBP_PH_CMD1 = 3'b001,
    NBP_PH_ADDR = 3'b011,
    NBP_PH_CMD2 = 3'b010,
    NBP_PH_WAIT = 3'b110,
    NBP_PH_DATA = 3'b111,
    NBP_PH_END = 3'b101
  } nbp_ph_t;

  nbp_cyc_if cyc ();
  nbp_ph_t ph;
  logic [2:0] acnt;
  logic [11:0] dcnt;
  logic pending;
  logic [11:0] col;
  logic [16:0] row;
  logic [7:0] cmd2;
  logic cmd2_en;
  logic wait_busy;
  logic is_write;
  logic [11:0] len;
  logic [2:0] rb_sync;
  logic rb_ready;
  logic [7:0] io_s1;
  logic [7:0] io_s2;
  logic [7:0] io_s3;
  logic [7:0] io_f;
  logic [3:0] wcnt;
  logic s_cle;
  logic s_ale;
  logic s_we_n;
  logic s_re_n;
  logic [7:0] s_io;
  logic s_oe;

  // Address byte selection per cycle
  function automatic logic [7:0] nbp_addr_byte(input logic [2:0] idx,
      input logic [11:0] c, input logic [16:0] r);
    case (idx)
      // column low byte, then high nibble
      3'h0: nbp_addr_byte = c[7:0];
      3'h1: nbp_addr_byte = {4'h0, c[11:8]};
      // row bytes; plane bit in row[6]
      3'h2: nbp_addr_byte = r[7:0];
      3'h3: nbp_addr_byte = r[15:8];
      3'h4: nbp_addr_byte = {7'h00, r[16]};
      default: nbp_addr_byte = 8'h00;
    endcase
  endfunction : nbp_addr_byte

  // Ready/busy pin: three stages, change taken when last two agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rb_sync <= 3'b111;
      rb_ready <= 1'b1;
    end else begin
      rb_sync <= {rb_sync[1:0], ready_busy_n_i};
      if (rb_sync[2] == rb_sync[1])
        rb_ready <= rb_sync[1];
    end
  end

  // Read bus: three flops, a byte counts once the last two agree;
  // the read low phase is stretched to cover this lag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      io_s3 <= 8'h00;
      io_f <= 8'h00;
    end else begin
      io_s1 <= io_i;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      if (io_s2 == io_s3)
        io_f <= io_s3;
    end
  end

  wire eng_idle = !pending;
  wire wait_go = (wcnt == 4'h0) && (!wait_busy || rb_ready);
  wire data_left = (dcnt != len);
  wire issue = eng_idle && !cyc.done;
  wire wr_take = (ph == NBP_PH_DATA) && is_write && issue &&
                 data_left && wdata_valid_i;

  assign cyc.req = issue && (
    (ph == NBP_PH_CMD1) || (ph == NBP_PH_ADDR) || (ph == NBP_PH_CMD2) ||
    ((ph == NBP_PH_DATA) && data_left && (!is_write || wdata_valid_i)));
  // kind is exclusive, never CLE with ALE
  assign cyc.kind = (ph == NBP_PH_ADDR) ? NBP_CYC_ADDR :
                    (ph == NBP_PH_DATA) ?
                    (is_write ? NBP_CYC_WDATA : NBP_CYC_RDATA) :
                    NBP_CYC_CMD;
  assign cyc.wbyte = (ph == NBP_PH_ADDR) ? nbp_addr_byte(acnt, col, row) :
                     (ph == NBP_PH_CMD2) ? cmd2 :
                     (ph == NBP_PH_DATA) ? wdata_i : op_cmd1_i;

  // Operation phases; caller owns command validity
  // command bytes pass unaltered
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ph <= NBP_PH_IDLE;
      acnt <= 3'h0;
      dcnt <= 12'h000;
      pending <= 1'b0;
      col <= 12'h000;
      row <= 17'h00000;
      cmd2 <= 8'h00;
      cmd2_en <= 1'b0;
      wait_busy <= 1'b0;
      is_write <= 1'b0;
      len <= 12'h000;
      wcnt <= 4'(`NBP_BUSY_GUARD_CYC);
    end else begin
      // Guard restarts on every entry into the wait phase
      if (ph != NBP_PH_WAIT)
        wcnt <= 4'(`NBP_BUSY_GUARD_CYC);
      else if (wcnt != 4'h0)
        wcnt <= wcnt - 4'h1;
      if (cyc.req)
        pending <= 1'b1;
      else if (cyc.done)
        pending <= 1'b0;
      case (ph)
        NBP_PH_IDLE: begin
          if (op_start_i && rb_ready) begin
            col <= op_col_i;
            row <= op_row_i;
            cmd2 <= op_cmd2_i;
            cmd2_en <= op_cmd2_en_i;
            wait_busy <= op_wait_busy_i;
            is_write <= op_is_write_i;
            len <= op_len_i;
            acnt <= 3'h0;
            dcnt <= 12'h000;
            ph <= NBP_PH_CMD1;
          end
        end
        NBP_PH_CMD1: if (cyc.done) begin
          ph <= op_addr_en_i ? NBP_PH_ADDR :
                cmd2_en ? NBP_PH_CMD2 : NBP_PH_WAIT;
        end
        NBP_PH_ADDR: if (cyc.done) begin
          acnt <= acnt + 3'h1;
          if (acnt == 3'(`NBP_ADDR_CYCLES - 1))
            ph <= (cmd2_en && !is_write) ? NBP_PH_CMD2 : NBP_PH_WAIT;
        end
        NBP_PH_CMD2: if (cyc.done) begin
          ph <= NBP_PH_WAIT;
        end
        NBP_PH_WAIT: begin
          // Busy can fall after the last strobe and the filter lags;
          // the guard keeps a stale ready from passing the wait
          if (wait_go) begin
            ph <= (is_write && cmd2_en && data_left) ? NBP_PH_DATA :
                  (is_write && cmd2_en) ? NBP_PH_CMD2 :
                  data_left ? NBP_PH_DATA : NBP_PH_END;
            // Closing command goes out after the data; a write with no address phase also sends it once before the data
            if (is_write && cmd2_en && !data_left)
              cmd2_en <= 1'b0;
          end
        end
        NBP_PH_DATA: begin
          if (cyc.done)
            dcnt <= dcnt + 12'h001;
          if (cyc.done && (dcnt + 12'h001 == len))
            ph <= (is_write && cmd2_en) ? NBP_PH_WAIT : NBP_PH_END;
        end
        NBP_PH_END: ph <= NBP_PH_IDLE;
        default: ph <= NBP_PH_IDLE;
      endcase
    end
  end

  nbp_strobe u_strobe (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cyc(cyc.eng),
    .io_in_i(io_f),
    .cmd_latch_o(s_cle),
    .addr_latch_o(s_ale),
    .write_strobe_n_o(s_we_n),
    .read_strobe_n_o(s_re_n),
    .io_out_o(s_io),
    .io_oe_o(s_oe)
  );

  // Registered pin and user outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      chip_enable_n_o <= 1'b1;
      cmd_latch_o <= 1'b0;
      addr_latch_o <= 1'b0;
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      write_protect_n_o <= 1'b0;
      io_o <= 8'h00;
      io_oe_o <= 1'b0;
      op_busy_o <= 1'b0;
      op_done_o <= 1'b0;
      wdata_ready_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      // chip enable low only within operation
      chip_enable_n_o <= (ph == NBP_PH_IDLE) || (ph == NBP_PH_END);
      cmd_latch_o <= s_cle;
      addr_latch_o <= s_ale;
      write_strobe_n_o <= s_we_n;
      read_strobe_n_o <= s_re_n;
      write_protect_n_o <= write_protect_en_i;
      io_o <= s_io;
      io_oe_o <= s_oe;
      op_busy_o <= (ph != NBP_PH_IDLE);
      op_done_o <= (ph == NBP_PH_END);
      wdata_ready_o <= wr_take;
      rdata_valid_o <= cyc.done && (ph == NBP_PH_DATA) && !is_write;
      if (cyc.done && (ph == NBP_PH_DATA) && !is_write)
        rdata_o <= cyc.rbyte;
    end
  end
endmodule : nbp_host

// ### verif/nbp_host_sva.sv
// Port checker for the host NAND pin sequencer.
// Assumes the bind below attaches it to the nbp_host top module.
`timescale 1ns/1ps
module nbp_host_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic op_done_o,
  input wire logic chip_enable_n_o,
  input wire logic cmd_latch_o,
  input wire logic addr_latch_o,
  input wire logic write_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic [7:0] io_o,
  input wire logic io_oe_o,
  input wire logic ready_busy_n_i
);
  int acnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Address strobes seen in the running operation
  always_ff @(posedge clk_i) begin
    if (!nrst_i) acnt <= 0;
    else if (op_done_o) acnt <= 0;
    else if ($rose(write_strobe_n_o) && addr_latch_o) acnt <= acnt + 1;
  end
  sequence s_we_low;
    (!write_strobe_n_o) [*3] ##1 write_strobe_n_o;
  endsequence
  sequence s_re_low;
    (!read_strobe_n_o) [*8] ##1 read_strobe_n_o;
  endsequence
  sequence s_steady;
    ($stable(cmd_latch_o) && $stable(addr_latch_o) && $stable(io_o)) [*3];
  endsequence
  property p_one_latch; !(cmd_latch_o && addr_latch_o); endproperty
  property p_we_pulse; $fell(write_strobe_n_o) |-> s_we_low; endproperty
  property p_latch_hold; $fell(write_strobe_n_o) |=> s_steady; endproperty
  property p_we_drive;
    !write_strobe_n_o |-> !chip_enable_n_o && io_oe_o;
  endproperty
  property p_re_pulse; $fell(read_strobe_n_o) |-> s_re_low; endproperty
  property p_read_quiet;
    !read_strobe_n_o |-> !cmd_latch_o && !addr_latch_o && write_strobe_n_o
      && !chip_enable_n_o && !io_oe_o;
  endproperty
  property p_ready_wait;
    (!ready_busy_n_i) [*6] |-> write_strobe_n_o && read_strobe_n_o;
  endproperty
  property p_addr_five; op_done_o |-> (acnt == 0 || acnt == 5); endproperty
  a_one_latch: assert property (p_one_latch)
    else $error("command and address latch high together");
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe low phase not three cycles");
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch or data moved inside a write cycle");
  a_we_drive: assert property (p_we_drive)
    else $error("write strobe low without chip enable or drive");
  a_re_pulse: assert property (p_re_pulse)
    else $error("read strobe low phase not eight cycles");
  a_read_quiet: assert property (p_read_quiet)
    else $error("read strobe low with other controls active");
  a_ready_wait: assert property (p_ready_wait)
    else $error("strobe while device busy");
  a_addr_five: assert property (p_addr_five)
    else $error("address cycle count not five");
endmodule : nbp_host_sva
bind nbp_host nbp_host_sva nbp_host_sva_inst (.clk_i, .nrst_i, .op_done_o,
  .chip_enable_n_o, .cmd_latch_o, .addr_latch_o, .write_strobe_n_o,
  .read_strobe_n_o, .io_o, .io_oe_o, .ready_busy_n_i);

// ### verif/nbp_nand_model.sv
// Behavioural NAND device: latches, small page, busy and protect.
// Assumes the bench resolves the shared bus and the ready pull-up.
`timescale 1ns/1ps
module nbp_nand_model #(
  parameter int BUSY_NS = 400,
  parameter int ACC_NS = 20
) (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic rb_low_o
);
  logic [7:0] cmd;
  logic [7:0] abyte [0:4];
  // one short page stands for the whole array
  logic [7:0] pg [0:64];
  logic [7:0] dbuf [0:64];
  logic [5:0] col;
  logic plane;
  int acnt;
  int n_busy;
  initial begin
    io_o = 8'h00;
    io_oe_o = 1'b0;
    rb_low_o = 1'b0;
    acnt = 0;
    n_busy = 0;
    col = 6'h00;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      cmd = io_i;
      if (io_i == 8'h80 || io_i == 8'h00) acnt = 0;
      if (io_i == 8'h30) dbuf = pg;
      if (io_i == 8'h30 || (io_i == 8'h10 && wp_n_i)) begin
        rb_low_o = 1'b1;
        n_busy++;
        rb_low_o <= #(BUSY_NS) 1'b0;
        if (io_i == 8'h10) pg = dbuf;
      end
    end else if (!ce_n_i && ale_i) begin
      if (acnt < 5) abyte[acnt] = io_i;
      if (acnt < 5) acnt++;
      col = abyte[0][5:0];
      plane = abyte[2][6];
    end else if (!ce_n_i) begin
      dbuf[col] = io_i;
      col++;
    end
  end
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      io_o <= #(ACC_NS) dbuf[col];
      io_oe_o <= #(ACC_NS) 1'b1;
      col++;
    end
  end
  always @(posedge re_n_i or posedge ce_n_i) io_oe_o <= #10 1'b0;
endmodule : nbp_nand_model

// ### verif/test_nbp_host.sv
// Self-checking bench for nbp_host against the behavioural device.
// Assumes the package and header of hw/ are compiled first.
`timescale 1ns/1ps
module test_nbp_host;
  import nbp_pkg::*;
  logic clk_i, nrst_i, op_start_i, op_addr_en_i, op_cmd2_en_i;
  logic op_wait_busy_i, op_is_write_i, wdata_valid_i, write_protect_en_i;
  logic [7:0] op_cmd1_i, op_cmd2_i, wdata_i, rdata_o, io_o, io_i;
  logic [7:0] mdl_io, flt;
  logic [11:0] op_col_i, op_len_i;
  logic [16:0] op_row_i;
  logic op_busy_o, op_done_o, wdata_ready_o, rdata_valid_o, chip_enable_n_o;
  logic cmd_latch_o, addr_latch_o, write_strobe_n_o, read_strobe_n_o;
  logic write_protect_n_o, io_oe_o, mdl_oe, rb_low, ready_busy_n_i;
  logic [7:0] rd [0:63];
  int nrd, n_mismatch, samples_checked;
  // one shared bus; idle bus wanders
  assign io_i = io_oe_o ? io_o : (mdl_oe ? mdl_io : flt);
  assign ready_busy_n_i = !rb_low;
  always @(posedge clk_i) flt <= flt + 8'h35;
  nbp_host nbp_host_inst (.clk_i, .nrst_i, .op_start_i, .op_cmd1_i,
    .op_addr_en_i, .op_col_i, .op_row_i, .op_cmd2_en_i, .op_cmd2_i,
    .op_wait_busy_i, .op_is_write_i, .op_len_i, .wdata_valid_i, .wdata_i,
    .write_protect_en_i, .op_busy_o, .op_done_o, .wdata_ready_o,
    .rdata_valid_o, .rdata_o, .chip_enable_n_o, .cmd_latch_o, .addr_latch_o,
    .write_strobe_n_o, .read_strobe_n_o, .write_protect_n_o,
    .ready_busy_n_i, .io_i, .io_o, .io_oe_o);
  nbp_nand_model nbp_nand_model_inst (.ce_n_i(chip_enable_n_o),
    .cle_i(cmd_latch_o), .ale_i(addr_latch_o), .we_n_i(write_strobe_n_o),
    .re_n_i(read_strobe_n_o), .wp_n_i(write_protect_n_o), .io_i(io_i),
    .io_o(mdl_io), .io_oe_o(mdl_oe), .rb_low_o(rb_low));
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One user operation; write bytes count up from base
  task automatic run_op(input logic [7:0] c1, logic ae, logic [7:0] c2,
    logic wr, logic [11:0] n, logic [7:0] base);
    int w;
    int wk;
    @(posedge clk_i);
    op_cmd1_i <= c1;
    op_addr_en_i <= ae;
    op_cmd2_en_i <= ae;
    op_cmd2_i <= c2;
    op_is_write_i <= wr;
    op_len_i <= n;
    wdata_valid_i <= wr;
    wdata_i <= base;
    op_start_i <= 1'b1;
    nrd = 0;
    w = 0;
    wk = 0;
    while (op_done_o !== 1'b1 && w < 20000) begin
      @(posedge clk_i);
      w++;
      if (op_busy_o === 1'b1) op_start_i <= 1'b0;
      if (wdata_ready_o === 1'b1) wk++;
      if (wdata_ready_o === 1'b1) wdata_i <= base + 8'(wk);
      if (wk >= n) wdata_valid_i <= 1'b0;
      if (rdata_valid_o === 1'b1) rd[nrd] = rdata_o;
      if (rdata_valid_o === 1'b1) nrd++;
    end
    if (w >= 20000) chk("op done", 8'h01, 8'h00);
  endtask : run_op
  task automatic t_reset_pins;
    chk("ce_n", 8'h01, {7'h00, chip_enable_n_o});
    chk("wp_n", 8'h00, {7'h00, write_protect_n_o});
    chk("io_oe", 8'h00, {7'h00, io_oe_o});
  endtask : t_reset_pins
  task automatic t_program;
    write_protect_en_i <= 1'b1;
    run_op(8'h80, 1'b1, 8'h10, 1'b1, 12'h008, 8'h40);
    chk("addr0", 8'h05, nbp_nand_model_inst.abyte[0]);
    chk("addr1", 8'h0A, nbp_nand_model_inst.abyte[1]);
    chk("addr2", 8'h45, nbp_nand_model_inst.abyte[2]);
    chk("addr3", 8'h23, nbp_nand_model_inst.abyte[3]);
    chk("addr4", 8'h01, nbp_nand_model_inst.abyte[4]);
    chk("plane", 8'h01, {7'h00, nbp_nand_model_inst.plane});
    chk("busy", 8'h01, 8'(nbp_nand_model_inst.n_busy));
  endtask : t_program
  task automatic t_read(input logic [7:0] base);
    run_op(8'h00, 1'b1, 8'h30, 1'b0, 12'h008, 8'h00);
    chk("rd count", 8'h08, 8'(nrd));
    for (int i = 0; i < 8; i++) chk("rdata", base + 8'(i), rd[i]);
  endtask : t_read
  task automatic t_protect;
    write_protect_en_i <= 1'b0;
    run_op(8'h80, 1'b1, 8'h10, 1'b1, 12'h008, 8'h90);
    chk("busy", 8'h02, 8'(nbp_nand_model_inst.n_busy));
    t_read(8'h40);
    write_protect_en_i <= 1'b1;
  endtask : t_protect
  task automatic t_cmd_only;
    run_op(8'hFF, 1'b0, 8'h00, 1'b0, 12'h000, 8'h00);
    chk("cmd", 8'hFF, nbp_nand_model_inst.cmd);
  endtask : t_cmd_only
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Free-running clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Watchdog well beyond the thousand or so cycles needed
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {nrst_i, op_start_i, op_addr_en_i, op_cmd2_en_i, op_wait_busy_i} = 5'h00;
    {op_is_write_i, wdata_valid_i, write_protect_en_i} = 3'h0;
    {op_cmd1_i, op_cmd2_i, wdata_i, flt, op_len_i} = 44'h0;
    op_col_i = 12'hA05;
    op_row_i = 17'h12345;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_i);
    t_reset_pins();
    nrst_i <= 1'b1;
    op_wait_busy_i <= 1'b1;
    t_program();
    t_read(8'h40);
    t_protect();
    t_cmd_only();
    end_sim();
  end
endmodule : test_nbp_host
